/* rtl/tmtc_pkg.sv */
package tmtc_pkg;
    // ---------------------------------------------------------------
    // register bus geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ---------------------------------------------------------------
    // configuration register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_TAP_WINDOW = 8'h1F;
    localparam logic [7:0] OFS_TOTAL_TIME = 8'h2F;
    localparam logic [7:0] OFS_LATENCY = 8'h30;
    localparam logic [7:0] OFS_SELF_TEST = 8'h3A;
    localparam logic [7:0] OFS_MAIN_CTRL = 8'h1B;
    localparam logic [7:0] OFS_WAKE_THR = 8'h5A;
    localparam logic [7:0] OFS_TILT_ANGLE = 8'h5C;
    localparam logic [7:0] OFS_HYST = 8'h5F;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_TAP_WINDOW = 8'hA0;
    localparam logic [7:0] RST_TOTAL_TIME = 8'h24;
    localparam logic [7:0] RST_LATENCY = 8'h28;
    localparam logic [7:0] RST_SELF_TEST = 8'h00;
    localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
    localparam logic [7:0] RST_WAKE_THR = 8'h08;
    localparam logic [7:0] RST_TILT_ANGLE = 8'h0C;
    localparam logic [7:0] RST_HYST = 8'h14;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ---------------------------------------------------------------
    // fields and codes
    // ---------------------------------------------------------------
    localparam int OPERATE_BIT = 7;
    localparam int HYST_MSB = 4;
    localparam logic [4:0] HYST_MASK = 5'h1F;
    localparam logic [7:0] SELF_TEST_ON = 8'hCA;
    localparam logic [7:0] SELF_TEST_OFF = 8'h00;
    localparam logic [11:0] SELF_TEST_OFFSET = 12'h040;
    localparam logic [11:0] ZERO12 = 12'h000;

    // ---------------------------------------------------------------
    // controller registers (software port)
    // ---------------------------------------------------------------
    localparam logic [3:0] C_ADDR = 4'h0;
    localparam logic [3:0] C_WDATA = 4'h1;
    localparam logic [3:0] C_CMD = 4'h2;
    localparam logic [3:0] C_RDATA = 4'h3;
    localparam logic [3:0] C_STATUS = 4'h4;
    localparam logic [3:0] C_IRQ_CLR = 4'h5;
    localparam logic [3:0] C_IRQ_EN = 4'h6;
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ = 1;
    localparam int CMD_RMW_HYST = 2;
    localparam int EV_DONE = 0;
    localparam int EV_REFUSED = 1;
    localparam int N_EV = 2;

    typedef enum logic [1:0] {
        TMTC_IDLE,
        TMTC_READ,
        TMTC_RMW_WR,
        TMTC_WRITE
    } tmtc_state_e;
endpackage

/* rtl/tmtc_if.sv */
`timescale 1ns/10ps
interface tmtc_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport dev (
        input wr,
        input rd,
        input addr,
        input wdata,
        output rdata
    );
    modport host (
        output wr,
        output rd,
        output addr,
        output wdata,
        input rdata
    );
endinterface // tmtc_if

/* rtl/tmtc_cfg_reg.sv */
`timescale 1ns/10ps
// one configuration byte with its own reset value and write decode
module tmtc_cfg_reg #(
    parameter logic [7:0] OFFSET = 8'h00,
    parameter logic [7:0] RESET = 8'h00
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic hit_o,
    output logic [7:0] value_o
);
    assign hit_o = (addr_i == OFFSET);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_o <= RESET;
        end else if (wr_i && hit_o) begin
            value_o <= wdata_i;
        end
    end
endmodule // tmtc_cfg_reg

/* rtl/tmtc_dev.sv */
`timescale 1ns/10ps
module tmtc_dev (
    input wire logic clk_i,
    input wire logic rst_n_i,
    tmtc_if.dev bus,
    output logic operate_o,
    output logic [7:0] tap_window_time_o,
    output logic [7:0] double_tap_total_time_o,
    output logic [7:0] tap_latency_time_o,
    output logic [7:0] motion_wake_threshold_o,
    output logic [7:0] tilt_angle_threshold_o,
    output logic [4:0] orientation_hysteresis_o,
    output logic self_test_active_o,
    output logic [11:0] axis_offset_o
);
    import tmtc_pkg::*;

    // ---------------------------------------------------------------
    // register bank
    // ---------------------------------------------------------------
    localparam int NREG = 8;
    localparam logic [7:0] OFS [NREG] = '{OFS_TAP_WINDOW, OFS_TOTAL_TIME, OFS_LATENCY, OFS_SELF_TEST,
        OFS_MAIN_CTRL, OFS_WAKE_THR, OFS_TILT_ANGLE, OFS_HYST};
    localparam logic [7:0] RST [NREG] = '{RST_TAP_WINDOW, RST_TOTAL_TIME, RST_LATENCY, RST_SELF_TEST,
        RST_MAIN_CTRL, RST_WAKE_THR, RST_TILT_ANGLE, RST_HYST};

    logic [NREG-1:0] hit;
    logic [7:0] val [NREG];
    logic [7:0] next_rdata;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_reg
            tmtc_cfg_reg #(
                .OFFSET(OFS[g]),
                .RESET(RST[g])
            ) u_reg (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .wr_i(bus.wr),
                .addr_i(bus.addr),
                .wdata_i(bus.wdata),
                .hit_o(hit[g]),
                .value_o(val[g])
            );
        end
    endgenerate

    always_comb begin
        next_rdata = READ_UNMAPPED;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                next_rdata = val[i];
            end
        end
    end

    // read data stands one cycle after the read strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus.rdata <= READ_UNMAPPED;
        end else if (bus.rd) begin
            bus.rdata <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // values handed to the detection engines
    // ---------------------------------------------------------------
    // window timer in sample periods, read by the tap engine
    assign tap_window_time_o = val[0];
    assign double_tap_total_time_o = val[1];
    // tap engine counts jerk_index samples against these
    assign tap_latency_time_o = val[2];
    assign operate_o = val[4][OPERATE_BIT];
    assign motion_wake_threshold_o = val[5];
    // tilt threshold for the orientation engine
    assign tilt_angle_threshold_o = val[6];
    // only the low field reaches the engine
    assign orientation_hysteresis_o = val[7][HYST_MSB:0] & HYST_MASK;

    // only the exact enable code actuates
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            self_test_active_o <= 1'b0;
        end else begin
            self_test_active_o <= (val[3] == SELF_TEST_ON);
        end
    end

    // same constant shift on all three axes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            axis_offset_o <= ZERO12;
        end else begin
            axis_offset_o <= (val[3] == SELF_TEST_ON) ? SELF_TEST_OFFSET : ZERO12;
        end
    end
endmodule // tmtc_dev

/* rtl/tmtc_host.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
// Contract
// - timer counts are sample_rate periods
// - total time caps double tap above-threshold time
// - latency bounds counted above-threshold samples
// - single tap reported at window end
// - window spans whole tap event
// - host should set window near 0.4 s
// - code CA enables self-test, 00 restores
// - self-test offsets all three axes
// - wake threshold resets to 0x08
// - tilt angle resets to 0x0C
// - host keeps tilt angle above 10 degrees
// - five-bit hysteresis field, default 0x14
// - host preserves reserved hysteresis bits
// - host clears operate_bit before changes
// - orientation changes reported by engine
// - jerk_index is summed absolute differences
// - tap length between duration limits
module tmtc_host (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] sw_addr_i,
    input wire logic [7:0] sw_wdata_i,
    input wire logic sw_wr_i,
    input wire logic sw_rd_i,
    output logic [7:0] sw_rdata_o,
    output logic irq_o,
    tmtc_if.host bus
);
    import tmtc_pkg::*;

    logic [7:0] tgt_addr;
    logic [7:0] tgt_wdata;
    logic [7:0] rd_result;
    logic [N_EV-1:0] status;
    logic [N_EV-1:0] irq_en;
    logic [N_EV-1:0] ev;
    logic operate_shadow;
    tmtc_state_e state;
    logic cmd_wr;
    logic busy;
    logic refuse;
    logic rmw;
    logic rd_valid;

    assign cmd_wr = sw_wr_i && (sw_addr_i == C_CMD);
    // busy spans the whole command, so software polls it instead of counting cycles
    // a command written while busy is ignored
    assign busy = (state != TMTC_IDLE);

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgt_addr <= 8'h00;
            tgt_wdata <= 8'h00;
            irq_en <= '0;
        end else if (sw_wr_i) begin
            if (sw_addr_i == C_ADDR) begin
                tgt_addr <= sw_wdata_i;
            end
            if (sw_addr_i == C_WDATA) begin
                tgt_wdata <= sw_wdata_i;
            end
            if (sw_addr_i == C_IRQ_EN) begin
                irq_en <= sw_wdata_i[N_EV-1:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_rdata_o <= 8'h00;
        end else if (sw_rd_i) begin
            case (sw_addr_i)
                C_ADDR: sw_rdata_o <= tgt_addr;
                C_WDATA: sw_rdata_o <= tgt_wdata;
                C_RDATA: sw_rdata_o <= rd_result;
                C_STATUS: sw_rdata_o <= {5'h00, busy, status};
                C_IRQ_EN: sw_rdata_o <= {6'h00, irq_en};
                // the clear register is write-only and reads as zero
                default: sw_rdata_o <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // command sequencer
    // ---------------------------------------------------------------
    // refuse config writes while operate_bit is set
    // a hysteresis update always writes its own register, whatever the target address holds
    assign refuse = operate_shadow && !sw_wdata_i[CMD_READ]
        && (sw_wdata_i[CMD_RMW_HYST] || (tgt_addr != OFS_MAIN_CTRL));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= TMTC_IDLE;
        end else begin
            case (state)
                TMTC_IDLE: begin
                    if (cmd_wr && !refuse) begin
                        if (sw_wdata_i[CMD_READ]) state <= TMTC_READ;
                        else if (sw_wdata_i[CMD_RMW_HYST]) state <= TMTC_READ;
                        else if (sw_wdata_i[CMD_WRITE]) state <= TMTC_WRITE;
                    end
                end
                // read data stand from the cycle after the strobe, so wait for them
                TMTC_READ: begin
                    if (rd_valid) begin
                        state <= rmw ? TMTC_RMW_WR : TMTC_IDLE;
                    end
                end
                TMTC_RMW_WR: state <= TMTC_IDLE;
                TMTC_WRITE: state <= TMTC_IDLE;
                default: state <= TMTC_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read data wait
    // ---------------------------------------------------------------
    // rd_valid marks the first cycle in which the device read data stand
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= (state == TMTC_READ) && !rd_valid;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rmw <= 1'b0;
        end else if (state == TMTC_IDLE && cmd_wr) begin
            rmw <= sw_wdata_i[CMD_RMW_HYST] && !sw_wdata_i[CMD_READ];
        end
    end

    // bus strobes: one cycle each
    // address and data stay put between strobes, so the device sees no stray change
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.addr <= 8'h00;
            bus.wdata <= 8'h00;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            if (state == TMTC_IDLE && cmd_wr && !refuse) begin
                bus.addr <= sw_wdata_i[CMD_RMW_HYST] && !sw_wdata_i[CMD_READ] ? OFS_HYST : tgt_addr;
                bus.rd <= sw_wdata_i[CMD_READ] || sw_wdata_i[CMD_RMW_HYST];
                bus.wr <= !sw_wdata_i[CMD_READ] && !sw_wdata_i[CMD_RMW_HYST] && sw_wdata_i[CMD_WRITE];
                bus.wdata <= tgt_wdata;
            end else if (state == TMTC_READ && rd_valid && rmw) begin
                // keep reserved upper bits, replace the field
                bus.wr <= 1'b1;
                bus.wdata <= {bus.rdata[7:HYST_MSB+1], tgt_wdata[HYST_MSB:0]};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_result <= 8'h00;
        end else if (state == TMTC_READ && rd_valid) begin
            rd_result <= bus.rdata;
        end
    end

    // the device does not refuse writes itself, so the operate level is tracked from our own writes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            operate_shadow <= 1'b0;
        end else if (bus.wr && bus.addr == OFS_MAIN_CTRL) begin
            operate_shadow <= bus.wdata[OPERATE_BIT];
        end
    end

    // ---------------------------------------------------------------
    // interrupts: set wins over clear
    // ---------------------------------------------------------------
    assign ev[EV_DONE] = (state == TMTC_WRITE) || (state == TMTC_RMW_WR) || (state == TMTC_READ && rd_valid && !rmw);
    assign ev[EV_REFUSED] = (state == TMTC_IDLE) && cmd_wr && refuse;

    genvar g;
    generate
        for (g = 0; g < N_EV; g++) begin : g_ev
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    status[g] <= 1'b0;
                end else if (ev[g]) begin
                    status[g] <= 1'b1;
                end else if (sw_wr_i && sw_addr_i == C_IRQ_CLR && sw_wdata_i[g]) begin
                    status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // level output: stays high while any pending event is enabled, until software clears or disables it
    assign irq_o = |(status & irq_en);
endmodule // tmtc_host

/* verif/tmtc_assertions.sv */
`timescale 1ns/10ps
module tmtc_assertions
    import tmtc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic operate_o,
    input wire logic self_test_active_o,
    input wire logic [11:0] axis_offset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----------------------------------------
    // shadow of the device registers
    // ----------------------------------------
    logic [7:0] shadow [256];
    logic [255:0] seen;
    logic rd_q;
    logic [7:0] exp_q;
    function automatic bit mapped(input logic [7:0] a);
        return a inside {OFS_TAP_WINDOW, OFS_TOTAL_TIME, OFS_LATENCY, OFS_SELF_TEST, OFS_MAIN_CTRL,
            OFS_WAKE_THR, OFS_TILT_ANGLE, OFS_HYST};
    endfunction
    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            OFS_TAP_WINDOW: return RST_TAP_WINDOW;
            OFS_TOTAL_TIME: return RST_TOTAL_TIME;
            OFS_LATENCY: return RST_LATENCY;
            OFS_WAKE_THR: return RST_WAKE_THR;
            OFS_TILT_ANGLE: return RST_TILT_ANGLE;
            OFS_HYST: return RST_HYST;
            default: return 8'h00;
        endcase
    endfunction
    // shadow needs no reset: seen gates every use of it
    always_ff @(posedge clk_i) begin
        if (wr) shadow[addr] <= wdata;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) seen <= '0;
        else if (wr && mapped(addr)) seen[addr] <= 1'b1;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= 1'b0;
            exp_q <= 8'h00;
        end else begin
            rd_q <= rd;
            exp_q <= !mapped(addr) ? 8'h00 : seen[addr] ? shadow[addr] : rst_val(addr);
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_read_back: assert property (rd_q |-> rdata == exp_q)
        else $error("device read data differs from shadow");
    chk_rdata_hold: assert property (!rd_q |-> $stable(rdata))
        else $error("device read data moved without a read");
    chk_wake_reset: assert property (rd && addr == OFS_WAKE_THR && !seen[addr] |=> rdata == 8'h08)
        else $error("wake threshold reset value wrong");
    chk_tilt_reset: assert property (rd && addr == OFS_TILT_ANGLE && !seen[addr] |=> rdata == 8'h0C)
        else $error("tilt angle reset value wrong");
    chk_hyst_keep: assert property (wr && addr == OFS_HYST && $past(rd, 2) && $past(addr, 2) == OFS_HYST
        |-> wdata[7:5] == rdata[7:5])
        else $error("reserved hysteresis bits not preserved");
    chk_operate_guard: assert property (wr && mapped(addr) && addr != OFS_MAIN_CTRL |-> !operate_o)
        else $error("config write while operating");
    chk_operate_set: assert property (wr && addr == OFS_MAIN_CTRL && wdata[OPERATE_BIT] |=> operate_o)
        else $error("operate level did not follow write");
    chk_selftest_on: assert property (wr && addr == OFS_SELF_TEST && wdata == SELF_TEST_ON
        |-> ##2 self_test_active_o)
        else $error("self-test not enabled by code");
    chk_selftest_off: assert property (wr && addr == OFS_SELF_TEST && wdata != SELF_TEST_ON
        |-> ##2 !self_test_active_o)
        else $error("self-test active with other code");
    chk_offset_track: assert property ($stable(self_test_active_o)
        |-> axis_offset_o == (self_test_active_o ? SELF_TEST_OFFSET : ZERO12))
        else $error("axis offset does not match self-test");
endmodule // tmtc_assertions

/* verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import tmtc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] sw_addr_i = 4'h0;
    logic [7:0] sw_wdata_i = 8'h00;
    logic sw_wr_i = 1'b0;
    logic sw_rd_i = 1'b0;
    logic [7:0] sw_rdata_o, win, tot, lat, wake, tilt, rd_v, st_v, wr_v;
    // bit 3 set keeps the tilt angle above ten degrees at 32 counts per g
    localparam logic [7:0] TILT_FLOOR = 8'h08;
    logic irq_o, operate_o, st_act;
    logic [4:0] hyst;
    logic [11:0] offs;
    int error_cnt = 0;
    int compares = 0;
    int mdl [256];
    logic [7:0] regs [8] = '{OFS_TAP_WINDOW, OFS_TOTAL_TIME, OFS_LATENCY, OFS_WAKE_THR, OFS_TILT_ANGLE,
        OFS_HYST, OFS_SELF_TEST, OFS_MAIN_CTRL};
    logic [7:0] rstv [8] = '{RST_TAP_WINDOW, RST_TOTAL_TIME, RST_LATENCY, RST_WAKE_THR, RST_TILT_ANGLE,
        RST_HYST, RST_SELF_TEST, RST_MAIN_CTRL};
    logic [7:0] st_codes [6] = '{8'hCA, 8'h55, 8'hCB, 8'h00, 8'hCA, 8'h00};
    tmtc_if bus_if ();
    tmtc_host tmtc_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
        .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .irq_o(irq_o), .bus(bus_if.host));
    tmtc_dev tmtc_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if.dev), .operate_o(operate_o),
        .tap_window_time_o(win), .double_tap_total_time_o(tot), .tap_latency_time_o(lat),
        .motion_wake_threshold_o(wake), .tilt_angle_threshold_o(tilt), .orientation_hysteresis_o(hyst),
        .self_test_active_o(st_act), .axis_offset_o(offs));
    tmtc_assertions tmtc_assertions_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr(bus_if.wr), .rd(bus_if.rd),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .operate_o(operate_o),
        .self_test_active_o(st_act), .axis_offset_o(offs));
    always #12.5 clk_i = ~clk_i;
    // ----------------------------------------
    // software port and checking tasks
    // ----------------------------------------
    task automatic give_verdict();
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sw_addr_i <= a;
        sw_wdata_i <= d;
        sw_wr_i <= 1'b1;
        @(posedge clk_i);
        sw_wr_i <= 1'b0;
        #1;
    endtask
    task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        sw_addr_i <= a;
        sw_rd_i <= 1'b1;
        @(posedge clk_i);
        sw_rd_i <= 1'b0;
        #1 d = sw_rdata_o;
    endtask
    // status is cleared first so each command reports only its own events
    task automatic do_cfg(input int cmd, input logic [7:0] a, input logic [7:0] d);
        int n;
        bit ok;
        ok = mdl[OFS_MAIN_CTRL][OPERATE_BIT] == 0 || a == OFS_MAIN_CTRL || cmd == CMD_READ;
        sw_wr(C_IRQ_CLR, 8'h03);
        sw_wr(C_ADDR, a);
        sw_wr(C_WDATA, d);
        sw_wr(C_CMD, 8'(1 << cmd));
        n = 0;
        do begin
            sw_rd(C_STATUS, st_v);
            n++;
        end while (st_v[2] !== 1'b0 && n < 40);
        if (st_v[2] !== 1'b0) begin
            error_cnt++;
            give_verdict();
        end
        sw_rd(C_RDATA, rd_v);
        cmp("refused", {11'h0, !ok}, {11'h0, st_v[EV_REFUSED]});
        cmp("done", {11'h0, ok}, {11'h0, st_v[EV_DONE]});
        if (ok && a inside {regs} && cmd == CMD_WRITE) mdl[a] = d;
        if (ok && cmd == CMD_RMW_HYST) mdl[OFS_HYST] = {mdl[OFS_HYST][7:5], d[4:0]};
        if (cmd == CMD_READ) cmp("rdata", 12'(mdl[a]), {4'h0, rd_v});
    endtask
    task automatic check_outs();
        cmp("window", 12'(mdl[OFS_TAP_WINDOW]), {4'h0, win});
        cmp("total", 12'(mdl[OFS_TOTAL_TIME]), {4'h0, tot});
        cmp("latency", 12'(mdl[OFS_LATENCY]), {4'h0, lat});
        cmp("wake", 12'(mdl[OFS_WAKE_THR]), {4'h0, wake});
        cmp("tilt", 12'(mdl[OFS_TILT_ANGLE]), {4'h0, tilt});
        cmp("hyst", 12'(mdl[OFS_HYST] & 8'h1F), {7'h0, hyst});
        cmp("operate", 12'(mdl[OFS_MAIN_CTRL] >> 7), {11'h0, operate_o});
        cmp("selftest", (mdl[OFS_SELF_TEST] == SELF_TEST_ON) ? 12'h1 : 12'h0, {11'h0, st_act});
        cmp("offset", (mdl[OFS_SELF_TEST] == SELF_TEST_ON) ? SELF_TEST_OFFSET : ZERO12, offs);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(21));
        mdl = '{default: 0};
        foreach (regs[i]) mdl[regs[i]] = rstv[i];
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        foreach (regs[i]) do_cfg(CMD_READ, regs[i], 8'h00);
        do_cfg(CMD_READ, 8'h77, 8'h00);
        check_outs();
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 5; i++) begin
                wr_v = 8'($urandom);
                if (regs[i] == OFS_TILT_ANGLE) wr_v = wr_v | TILT_FLOOR;
                do_cfg(CMD_WRITE, regs[i], wr_v);
            end
            do_cfg(CMD_WRITE, 8'h77, 8'hA5);
            do_cfg(CMD_RMW_HYST, OFS_HYST, 8'($urandom));
            foreach (regs[i]) do_cfg(CMD_READ, regs[i], 8'h00);
            check_outs();
        end
        foreach (st_codes[i]) begin
            do_cfg(CMD_WRITE, OFS_SELF_TEST, (i == 3) ? 8'($urandom) : st_codes[i]);
            check_outs();
        end
        sw_wr(C_IRQ_EN, 8'h02);
        sw_rd(C_IRQ_EN, rd_v);
        cmp("irq_en", 12'h002, {4'h0, rd_v});
        do_cfg(CMD_WRITE, OFS_MAIN_CTRL, 8'h80);
        do_cfg(CMD_READ, OFS_HYST, 8'h00);
        do_cfg(CMD_WRITE, OFS_WAKE_THR, 8'h3C);
        do_cfg(CMD_RMW_HYST, OFS_HYST, 8'($urandom));
        cmp("irq", 12'h1, {11'h0, irq_o});
        sw_wr(C_IRQ_EN, 8'h00);
        cmp("irq", 12'h0, {11'h0, irq_o});
        sw_wr(C_IRQ_EN, 8'h02);
        cmp("irq", 12'h1, {11'h0, irq_o});
        sw_wr(C_IRQ_CLR, 8'h02);
        cmp("irq", 12'h0, {11'h0, irq_o});
        do_cfg(CMD_WRITE, OFS_MAIN_CTRL, 8'h00);
        do_cfg(CMD_WRITE, OFS_TAP_WINDOW, 8'hA0);
        do_cfg(CMD_READ, OFS_WAKE_THR, 8'h00);
        check_outs();
        give_verdict();
    end
endmodule // tb_top
